// File: logic/pmx_pkg.sv
// Purpose: shared constants, register map and signal groups of the pin mux
// Assumes: 32-bit APB, one aligned word per register, narrow data in low bits
// Notes: ports B and C are handled as one 14-bit vector, B in the low bits

package pmx_pkg;

    // port widths
    localparam int PA_W = 8;
    localparam int PB_W = 6;
    localparam int PC_W = 8;
    localparam int PBC_W = 14;
    localparam int SYNC_W = 22;

    // register byte offsets
    localparam logic [7:0] OFS_PA_DATA = 8'h00;
    localparam logic [7:0] OFS_PB_DATA = 8'h04;
    localparam logic [7:0] OFS_PB_DIR = 8'h08;
    localparam logic [7:0] OFS_PB_FSEL = 8'h0C;
    localparam logic [7:0] OFS_PC_DATA = 8'h10;
    localparam logic [7:0] OFS_PC_DIR = 8'h14;
    localparam logic [7:0] OFS_PC_FSEL = 8'h18;

    // reset values: direction 1 means input, function select 0 means port
    localparam logic [5:0] RST_PB_DATA = 6'h00;
    localparam logic [5:0] RST_PB_DIR = 6'h3F;
    localparam logic [5:0] RST_PB_FSEL = 6'h00;
    localparam logic [7:0] RST_PC_DATA = 8'h00;
    localparam logic [7:0] RST_PC_DIR = 8'hFF;
    localparam logic [7:0] RST_PC_FSEL = 8'h00;

    // port A bit positions of the always-on functions
    localparam int PA_BIT_NMI = 0;
    localparam int PA_BIT_STOP_A = 1;
    localparam int PA_BIT_STOP_B = 2;
    localparam int PA_IRQ_LSB = 1;
    localparam int PA_BIT_TRIG_A = 6;
    localparam int PA_BIT_TRIG_B = 7;

    // port B bit positions in control operation
    localparam int PB_BIT_OUT_A = 0;
    localparam int PB_BIT_OUT_B = 1;
    localparam int PB_BIT_CNT_A = 2;
    localparam int PB_BIT_DIR_A = 3;
    localparam int PB_BIT_CNT_B = 4;
    localparam int PB_BIT_DIR_B = 5;

    // port C bit positions in control operation
    localparam int PC_GT_OUT_LSB = 0;
    localparam int PC_BIT_EC_OUT = 4;
    localparam int PC_BIT_GT_CLK = 5;
    localparam int PC_BIT_EC_CLK = 6;
    localparam int PC_BIT_CAP_X = 7;

    // bits whose peripheral function drives the pin, {port C, port B}
    localparam logic [13:0] PBC_CTRL_DRIVES = 14'h07C3;

    // always-on functions of port A
    typedef struct packed {
        logic nmiIn;
        logic inverterTimerAStopIn;
        logic inverterTimerBStopIn;
        logic [6:0] externalIrqIn;
        logic converterATriggerIn;
        logic converterBTriggerIn;
    } pmx_pa_func_s;

    // inputs toward the up/down counter channels
    typedef struct packed {
        logic updownACountIn;
        logic updownBCountIn;
        logic updownADirectionIn;
        logic updownBDirectionIn;
        logic updownAClearIn;
        logic updownBClearIn;
        logic updownACaptureIrq0;
        logic updownACaptureIrq1;
        logic updownBCaptureIrq0;
        logic updownBCaptureIrq1;
    } pmx_upd_in_s;

    // outputs of the up/down counter channels
    typedef struct packed {
        logic updownAPulseOut;
        logic updownBPulseOut;
    } pmx_upd_out_s;

    // inputs toward the general timer and the event counter
    typedef struct packed {
        logic generalTimerClockIn;
        logic generalTimerClearIn;
        logic [1:0] generalTimerCaptureIrq;
        logic eventCounterClockIn;
        logic eventCounterClearIn;
        logic eventCounterCaptureIrq0;
        logic eventCounterCaptureIrq1;
    } pmx_gt_in_s;

    // outputs of the general timer and the event counter
    typedef struct packed {
        logic [3:0] generalTimerPulseOut;
        logic eventCounterPulseOut;
    } pmx_gt_out_s;

endpackage

// File: logic/pmx_sync.sv
// Purpose: two-flop synchroniser for pin levels
// Assumes: inputs are asynchronous to sys_clk
// Notes: first stage feeds the second stage only

`timescale 1ns/1ps
`default_nettype none

module pmx_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] stable_q;

    // two stages, reset to a quiet low level
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            meta_q <= '0;
            stable_q <= '0;
        end else begin
            meta_q <= asyncIn;
            stable_q <= meta_q;
        end
    end

    assign syncOut = stable_q;

endmodule

`default_nettype wire

// File: logic/pmx_port_mux.sv
// Purpose: pin multiplexing and port logic of ports A, B and C
// Assumes: APB slave with zero wait states, single clock sys_clk
// Notes: every pin level passes two flops before any logic sees it

`timescale 1ns/1ps
`default_nettype none

module pmx_port_mux (
    input wire logic sys_clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // board pins
    input wire logic [7:0] portAPins,
    input wire logic [5:0] portBPinsIn,
    output logic [5:0] portBPinsOut,
    output logic [5:0] portBPinsOeN,
    input wire logic [7:0] portCPinsIn,
    output logic [7:0] portCPinsOut,
    output logic [7:0] portCPinsOeN,
    // peripheral side
    output pmx_pkg::pmx_pa_func_s portAFunc,
    output pmx_pkg::pmx_upd_in_s updownIn,
    input wire pmx_pkg::pmx_upd_out_s updownOut,
    output pmx_pkg::pmx_gt_in_s timerIn,
    input wire pmx_pkg::pmx_gt_out_s timerOut
);

    // register map, one aligned word each, unused bits read zero
    //   0x00  port A pin levels, read only, writes dropped quietly
    //   0x04  port B output latch, read returns pins or latch
    //   0x08  port B direction, 1 input, 0 output
    //   0x0C  port B function select, 1 peripheral operation
    //   0x10  port C output latch, same read rule as port B
    //   0x14  port C direction, 1 input, 0 output
    //   0x18  port C function select, 1 peripheral operation
    //   other addresses answer with an error and zero data
    // narrow fields sit in the low bits; upper lanes ignored
    // a write with lane 0 strobe low changes nothing
    // reset: direction all input, select all port, latch zero

    // synchronised pin levels
    logic [21:0] pinSync;
    logic [7:0] paSync;
    logic [13:0] pbcSync;

    // port B and C state, port C in the upper eight bits
    logic [13:0] pbcLatch_q;
    logic [13:0] pbcDir_q;
    logic [13:0] pbcFsel_q;
    logic [13:0] pbcPinOut_d;
    logic [13:0] pbcPinOut_q;
    logic [13:0] pbcOeN_d;
    logic [13:0] pbcOeN_q;
    logic [13:0] pbcPeriphOut;
    logic [13:0] pbcReadBack;
    logic [13:0] pbcFuncIn;

    // bus side
    logic setupPhase;
    logic wrEn;
    logic [31:0] rdData;
    logic rdMapped;
    logic [31:0] prdata_q;
    logic pslverr_q;

    // every pin passes two flops; port A cannot drive at all
    pmx_sync #(
        .WIDTH(pmx_pkg::SYNC_W)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .asyncIn({portCPinsIn, portBPinsIn, portAPins}),
        .syncOut(pinSync)
    );

    assign paSync = pinSync[7:0];
    assign pbcSync = pinSync[21:8];

    // port A bit use, live at all times:
    //   bit 0      non-maskable interrupt request
    //   bit 1      stop input of inverter timer A
    //   bit 2      stop input of inverter timer B
    //   bits 1..7  external interrupt requests 0 to 6
    //   bit 6      trigger of converter A
    //   bit 7      trigger of converter B
    // pins are shared, so one level may reach several inputs;
    // software masks what it does not want in the peripheral
    // the synchroniser delays every function by two edges

    // port A functions are wired with no gating at all
    always_comb begin
        portAFunc.nmiIn = paSync[pmx_pkg::PA_BIT_NMI];
        portAFunc.inverterTimerAStopIn = paSync[pmx_pkg::PA_BIT_STOP_A];
        portAFunc.inverterTimerBStopIn = paSync[pmx_pkg::PA_BIT_STOP_B];
        portAFunc.externalIrqIn = paSync[pmx_pkg::PA_IRQ_LSB +: 7];
        portAFunc.converterATriggerIn = paSync[pmx_pkg::PA_BIT_TRIG_A];
        portAFunc.converterBTriggerIn = paSync[pmx_pkg::PA_BIT_TRIG_B];
    end

    // peripheral outputs placed on their bit positions, zero elsewhere
    always_comb begin
        pbcPeriphOut = '0;
        pbcPeriphOut[pmx_pkg::PB_BIT_OUT_A] = updownOut.updownAPulseOut;
        pbcPeriphOut[pmx_pkg::PB_BIT_OUT_B] = updownOut.updownBPulseOut;
        pbcPeriphOut[pmx_pkg::PB_W + pmx_pkg::PC_GT_OUT_LSB +: 4] =
            timerOut.generalTimerPulseOut;
        pbcPeriphOut[pmx_pkg::PB_W + pmx_pkg::PC_BIT_EC_OUT] =
            timerOut.eventCounterPulseOut;
    end

    // each bit of ports B and C makes three choices:
    //   what level the pin driver gets, latch or peripheral
    //   whether the driver is on, direction bit or function
    //   what a peripheral input and a data read see
    // function select wins over direction in every case, so
    // a stale direction bit cannot fight a peripheral output;
    // an input function always floats its pin, whatever the
    // direction register holds
    // the drive bits per position are fixed in the package,
    // not programmable, since each peripheral pin has one sense

    // per-bit pin logic for ports B and C
    genvar gi;
    generate
        for (gi = 0; gi < pmx_pkg::PBC_W; gi++) begin : g_bit
            // control operation hands the pin to the peripheral
            assign pbcPinOut_d[gi] = pbcFsel_q[gi] ? pbcPeriphOut[gi] : pbcLatch_q[gi];
            // function decides the drive; direction bit ignored then
            assign pbcOeN_d[gi] = pbcFsel_q[gi] ? ~pmx_pkg::PBC_CTRL_DRIVES[gi]
                                                : pbcDir_q[gi];
            // peripherals only see a pin that is in control operation
            assign pbcFuncIn[gi] = pbcFsel_q[gi] & ~pmx_pkg::PBC_CTRL_DRIVES[gi] & pbcSync[gi];
            // output bits in port operation read back their latch
            assign pbcReadBack[gi] = (!pbcFsel_q[gi] && !pbcDir_q[gi]) ? pbcLatch_q[gi]
                                                                      : pbcSync[gi];
        end
    endgenerate

    // pin data registered so it never glitches on the board
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pbcPinOut_q <= '0;
        end else begin
            pbcPinOut_q <= pbcPinOut_d;
        end
    end

    // output enables registered apart; reset lets every pin float
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pbcOeN_q <= '1;
        end else begin
            pbcOeN_q <= pbcOeN_d;
        end
    end

    assign portBPinsOut = pbcPinOut_q[5:0];
    assign portBPinsOeN = pbcOeN_q[5:0];
    assign portCPinsOut = pbcPinOut_q[13:6];
    assign portCPinsOeN = pbcOeN_q[13:6];

    // port B bit use in peripheral operation:
    //   bit 0  pulse output of up/down counter A
    //   bit 1  pulse output of up/down counter B
    //   bit 2  count input A, also capture trigger A0
    //   bit 3  direction and clear input A, capture trigger A1
    //   bit 4  count input B, also capture trigger B0
    //   bit 5  direction and clear input B, capture trigger B1
    // inputs read zero while their bit is in port operation,
    // so a counter never counts on a pin used as plain i/o

    // up/down counter inputs; count and direction pins double as capture triggers
    always_comb begin
        updownIn.updownACountIn = pbcFuncIn[pmx_pkg::PB_BIT_CNT_A];
        updownIn.updownBCountIn = pbcFuncIn[pmx_pkg::PB_BIT_CNT_B];
        updownIn.updownADirectionIn = pbcFuncIn[pmx_pkg::PB_BIT_DIR_A];
        updownIn.updownBDirectionIn = pbcFuncIn[pmx_pkg::PB_BIT_DIR_B];
        updownIn.updownAClearIn = pbcFuncIn[pmx_pkg::PB_BIT_DIR_A];
        updownIn.updownBClearIn = pbcFuncIn[pmx_pkg::PB_BIT_DIR_B];
        updownIn.updownACaptureIrq0 = pbcFuncIn[pmx_pkg::PB_BIT_CNT_A];
        updownIn.updownACaptureIrq1 = pbcFuncIn[pmx_pkg::PB_BIT_DIR_A];
        updownIn.updownBCaptureIrq0 = pbcFuncIn[pmx_pkg::PB_BIT_CNT_B];
        updownIn.updownBCaptureIrq1 = pbcFuncIn[pmx_pkg::PB_BIT_DIR_B];
    end

    // port C bit use in peripheral operation:
    //   bits 0..3  general timer pulse outputs
    //   bit 4      event counter pulse output
    //   bit 5      general timer clock, clear and capture 0
    //   bit 6      event counter clock, clear and capture 0
    //   bit 7      capture 1 of both timers
    // the general timer gets only two capture requests here;
    // its other requests come from pins outside this block

    // general timer and event counter inputs from port C
    always_comb begin
        timerIn.generalTimerClockIn = pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_GT_CLK];
        timerIn.generalTimerClearIn = pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_GT_CLK];
        timerIn.generalTimerCaptureIrq = {pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_CAP_X],
                                          pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_GT_CLK]};
        timerIn.eventCounterClockIn = pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_EC_CLK];
        timerIn.eventCounterClearIn = pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_EC_CLK];
        timerIn.eventCounterCaptureIrq0 = pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_EC_CLK];
        timerIn.eventCounterCaptureIrq1 = pbcFuncIn[pmx_pkg::PB_W + pmx_pkg::PC_BIT_CAP_X];
    end

    // bus timing seen by software:
    //   setup cycle captures read data and the error flag
    //   access cycle completes at once, no wait states
    //   a write lands at the edge that ends the access cycle
    //   pin drivers follow one edge after that
    // back-to-back transfers need no idle cycle between them
    // the error flag stands only while psel and penable are high
    // read data stays on prdata until the next setup cycle

    // bus phases; only byte lane 0 holds register bits
    assign setupPhase = psel & ~penable;
    assign wrEn = psel & penable & pwrite & pstrb[0];

    // output latches of ports B and C
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pbcLatch_q <= {pmx_pkg::RST_PC_DATA, pmx_pkg::RST_PB_DATA};
        end else if (wrEn) begin
            if (paddr == pmx_pkg::OFS_PB_DATA) begin
                pbcLatch_q[5:0] <= pwdata[5:0];
            end else if (paddr == pmx_pkg::OFS_PC_DATA) begin
                pbcLatch_q[13:6] <= pwdata[7:0];
            end
        end
    end

    // per-bit direction, 1 is input
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pbcDir_q <= {pmx_pkg::RST_PC_DIR, pmx_pkg::RST_PB_DIR};
        end else if (wrEn) begin
            if (paddr == pmx_pkg::OFS_PB_DIR) begin
                pbcDir_q[5:0] <= pwdata[5:0];
            end else if (paddr == pmx_pkg::OFS_PC_DIR) begin
                pbcDir_q[13:6] <= pwdata[7:0];
            end
        end
    end

    // per-bit function select, 1 is peripheral operation
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pbcFsel_q <= {pmx_pkg::RST_PC_FSEL, pmx_pkg::RST_PB_FSEL};
        end else if (wrEn) begin
            if (paddr == pmx_pkg::OFS_PB_FSEL) begin
                pbcFsel_q[5:0] <= pwdata[5:0];
            end else if (paddr == pmx_pkg::OFS_PC_FSEL) begin
                pbcFsel_q[13:6] <= pwdata[7:0];
            end
        end
    end

    // read-back of the data registers, per bit:
    //   port operation, output: the latch, not the pin,
    //   so a loaded pin cannot corrupt read-modify-write
    //   anything else: the synchronised pin level
    // control outputs therefore read back what the peripheral
    // drove a few edges earlier
    // unused upper bits always read zero

    // read decode; port A data has no write side at all
    always_comb begin
        rdData = '0;
        rdMapped = 1'b1;
        if (paddr == pmx_pkg::OFS_PA_DATA) begin
            rdData[7:0] = paSync;
        end else if (paddr == pmx_pkg::OFS_PB_DATA) begin
            rdData[5:0] = pbcReadBack[5:0];
        end else if (paddr == pmx_pkg::OFS_PB_DIR) begin
            rdData[5:0] = pbcDir_q[5:0];
        end else if (paddr == pmx_pkg::OFS_PB_FSEL) begin
            rdData[5:0] = pbcFsel_q[5:0];
        end else if (paddr == pmx_pkg::OFS_PC_DATA) begin
            rdData[7:0] = pbcReadBack[13:6];
        end else if (paddr == pmx_pkg::OFS_PC_DIR) begin
            rdData[7:0] = pbcDir_q[13:6];
        end else if (paddr == pmx_pkg::OFS_PC_FSEL) begin
            rdData[7:0] = pbcFsel_q[13:6];
        end else begin
            rdMapped = 1'b0;
        end
    end

    // read data captured in the setup cycle so prdata comes from a flop
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            prdata_q <= '0;
        end else if (setupPhase) begin
            prdata_q <= pwrite ? '0 : rdData;
        end
    end

    // error flag taken at the same edge, gated onto the bus below
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pslverr_q <= 1'b0;
        end else if (setupPhase) begin
            pslverr_q <= ~rdMapped;
        end
    end

    // limitations: pins are sampled at the system clock only,
    // so pulses shorter than one period may be missed;
    // an unmapped write is refused with an error and no effect;
    // port A keeps no reset value, it has no storage;
    // peripheral outputs reach their pins one edge late,
    // a trade of latency for glitch-free drivers

    // zero wait states: every access phase completes at once
    assign pready = psel & penable;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q & psel & penable;

endmodule

`default_nettype wire

// File: verif/pmx_port_mux_chk.sv
// Purpose: port-level checks of the pin mux
// Assumes: one clock, synchronous active-high reset
// Notes: bound to pmx_port_mux at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module pmx_port_mux_chk (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] portAPins,
    input wire logic [5:0] portBPinsIn,
    input wire logic [5:0] portBPinsOeN,
    input wire logic [7:0] portCPinsOeN,
    input wire pmx_pkg::pmx_pa_func_s portAFunc,
    input wire pmx_pkg::pmx_upd_in_s updownIn,
    input wire pmx_pkg::pmx_gt_in_s timerIn
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    // enables passed as arguments so the property sees sampled values
    function automatic logic bOeNAll(input logic [5:0] b, input logic [7:0] c);
        return b == 6'h3F && c == 8'hFF;
    endfunction
    // reset itself is the cause here, so this one is never disabled
    a_reset_float: assert property (disable iff (1'b0) sys_rst |=> bOeNAll(portBPinsOeN, portCPinsOeN))
        else $error("pins driven after reset");
    // pin levels need two clean edges through the synchroniser
    a_nmi_follow: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
        portAFunc.nmiIn == $past(portAPins[0], 2)) else $error("nmi input lost");
    a_stop_follow: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
        {portAFunc.inverterTimerBStopIn, portAFunc.inverterTimerAStopIn} == $past(portAPins[2:1], 2))
        else $error("stop input lost");
    a_irq_trig_follow: assert property (!$past(sys_rst) && !$past(sys_rst, 2) |->
        portAFunc.externalIrqIn == $past(portAPins[7:1], 2)
        && {portAFunc.converterBTriggerIn, portAFunc.converterATriggerIn} == $past(portAPins[7:6], 2))
        else $error("irq or trigger input lost");
    a_porta_read: assert property (psel && !penable && !pwrite && paddr == 8'h00 |=>
        prdata == {24'h0, $past({portAFunc.externalIrqIn, portAFunc.nmiIn})}) else $error("port A read wrong");
    a_b_in_float: assert property (updownIn.updownACountIn |=> portBPinsOeN[2])
        else $error("port B input function driven");
    a_c_in_float: assert property (timerIn.eventCounterClockIn |=> portCPinsOeN[6])
        else $error("port C input function driven");
    a_capture_pair: assert property (updownIn.updownACaptureIrq0 == updownIn.updownACountIn
        && updownIn.updownBCaptureIrq1 == updownIn.updownBClearIn) else $error("capture pairing wrong");
    a_capture_pin: assert property (updownIn.updownACaptureIrq0 |-> $past(portBPinsIn[2], 2))
        else $error("capture trigger without pin");
    a_apb_answer: assert property (psel && penable |-> pready
        && pslverr == !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18}))
        else $error("bus answer wrong");
endmodule
bind pmx_port_mux pmx_port_mux_chk i_pmx_port_mux_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .portAPins(portAPins), .portBPinsOeN(portBPinsOeN), .portCPinsOeN(portCPinsOeN),
    .portAFunc(portAFunc), .updownIn(updownIn), .timerIn(timerIn), .portBPinsIn(portBPinsIn));
`default_nettype wire

// File: verif/pmx_board.sv
// Purpose: board side of ports B and C
// Assumes: an external driver sits on every pin
// Notes: the board yields wherever the chip drives
`timescale 1ns/1ps
`default_nettype none
module pmx_board (
    input wire logic [5:0] bOut,
    input wire logic [5:0] bOeN,
    input wire logic [7:0] cOut,
    input wire logic [7:0] cOeN,
    input wire logic [5:0] extB,
    input wire logic [7:0] extC,
    output logic [5:0] bIn,
    output logic [7:0] cIn
);
    // wire level per pin; a driving chip overrides the weak board source
    assign bIn = (bOeN & extB) | (~bOeN & bOut);
    assign cIn = (cOeN & extC) | (~cOeN & cOut);
endmodule
`default_nettype wire

// File: verif/pmx_port_mux_bench.sv
// Purpose: self-checking bench of the pin mux
// Assumes: zero-wait bus, peripherals held at fixed levels
// Notes: all stimulus lands by non-blocking assignment on the rising edge
`timescale 1ns/1ps
`default_nettype none
module pmx_port_mux_bench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] portAPins = 8'h00;
    logic [5:0] bIn, bOut, bOeN;
    logic [7:0] cIn, cOut, cOeN;
    logic [5:0] extB = 6'h15;
    logic [7:0] extC = 8'h3C;
    pmx_pkg::pmx_pa_func_s portAFunc;
    pmx_pkg::pmx_upd_in_s updownIn;
    pmx_pkg::pmx_upd_out_s updownOut = 2'b01;
    pmx_pkg::pmx_gt_in_s timerIn;
    pmx_pkg::pmx_gt_out_s timerOut = 5'h15;
    int failures = 0;
    int comparisons = 0;
    pmx_port_mux i_pmx_port_mux (.sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .portAPins(portAPins), .portBPinsIn(bIn), .portBPinsOut(bOut),
        .portBPinsOeN(bOeN), .portCPinsIn(cIn), .portCPinsOut(cOut), .portCPinsOeN(cOeN),
        .portAFunc(portAFunc), .updownIn(updownIn), .updownOut(updownOut), .timerIn(timerIn),
        .timerOut(timerOut));
    pmx_board i_pmx_board (.bOut(bOut), .bOeN(bOeN), .cOut(cOut), .cOeN(cOeN), .extB(extB),
        .extC(extC), .bIn(bIn), .cIn(cIn));
    // free-running system clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        if (failures == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one bus transfer; the request holds until pready is seen high or 16 edges have passed
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [32:0] r);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) failures++;
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [32:0] r;
        apb(1'b1, a, d, r);
        check({31'h0, r[32]}, 32'h0);
    endtask
    // unmapped places answer with an error and zero data
    task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        check(r[31:0], e);
        check({31'h0, r[32]}, {31'h0, a > 8'h18});
    endtask
    function automatic pmx_pkg::pmx_upd_in_s updExp(input logic [5:0] m);
        return {m[2], m[4], m[3], m[5], m[3], m[5], m[2], m[3], m[4], m[5]};
    endfunction
    function automatic pmx_pkg::pmx_gt_in_s tmrExp(input logic [7:0] m);
        return {m[5], m[5], m[7], m[5], m[6], m[6], m[6], m[7]};
    endfunction
    // set direction and select of one port, then judge pins, read-back and peripheral inputs
    task automatic portCase(input logic c, input logic [7:0] d, input logic [7:0] f);
        logic [31:0] base, eo, ev, pv, x;
        base = c ? 32'h10 : 32'h04;
        pv = c ? {27'h0, timerOut.eventCounterPulseOut, timerOut.generalTimerPulseOut}
               : {30'h0, updownOut.updownBPulseOut, updownOut.updownAPulseOut};
        wr(base[7:0] + 8'h04, {24'h0, d});
        wr(base[7:0] + 8'h08, {24'h0, f});
        idle(3);
        x = c ? {24'h0, extC} : {26'h0, extB};
        eo = (({24'h0, f} & (c ? 32'hE0 : 32'h3C)) | ({24'h0, ~f & d})) & (c ? 32'hFF : 32'h3F);
        ev = (({24'h0, f} & pv) | ({24'h0, ~f} & 32'hA5)) & ~eo & (c ? 32'hFF : 32'h3F);
        check(c ? {24'h0, cOeN} : {26'h0, bOeN}, eo);
        check((c ? {24'h0, cOut} : {26'h0, bOut}) & ~eo, ev);
        rdChk(base[7:0], (eo & x) | ev);
        if (c) check({24'h0, timerIn}, {24'h0, tmrExp(extC & f)});
        else check({22'h0, updownIn}, {22'h0, updExp(extB & f[5:0])});
    endtask
    logic [7:0] pat [2] = '{8'h96, 8'h69};
    logic [7:0] rv [6] = '{8'h15, 8'h3F, 8'h00, 8'h3C, 8'hFF, 8'h00};
    initial begin
        idle(10);
        sys_rst <= 1'b0;
        idle(3);
        check({18'h0, cOeN, bOeN}, 32'h3FFF);
        for (int i = 0; i < 6; i++) rdChk(8'(4 * i + 4), {24'h0, rv[i]});
        // port A: live levels and fixed alternate functions
        for (int i = 0; i < 2; i++) begin
            portAPins <= pat[i];
            idle(3);
            rdChk(8'h00, {24'h0, pat[i]});
            check({20'h0, portAFunc}, {20'h0, pat[i][0], pat[i][1], pat[i][2], pat[i][7:1], pat[i][6], pat[i][7]});
        end
        wr(8'h00, 32'hFF);
        rdChk(8'h00, 32'h69);
        wr(8'h04, 32'hA5);
        wr(8'h10, 32'hA5);
        portCase(1'b0, 8'h3E, 8'h00);
        portCase(1'b0, 8'h15, 8'h00);
        portCase(1'b0, 8'h00, 8'h3F);
        extB <= 6'h2A;
        portCase(1'b0, 8'h00, 8'h3F);
        portCase(1'b0, 8'h00, 8'h05);
        portCase(1'b1, 8'h0F, 8'h00);
        portCase(1'b1, 8'h00, 8'hFF);
        extC <= 8'hC3;
        portCase(1'b1, 8'hF0, 8'hA5);
        rdChk(8'h1C, 32'h0);
        rdChk(8'h40, 32'h0);
        // reset in mid-run drops every driver and selection
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        idle(3);
        check({18'h0, cOeN, bOeN}, 32'h3FFF);
        // a write with lane 0 strobe low must leave the select alone
        pstrb <= 4'hE;
        wr(8'h18, 32'hFF);
        pstrb <= 4'hF;
        rdChk(8'h0C, 32'h0);
        rdChk(8'h18, 32'h0);
        stop_test();
    end
    // a hung transfer must not stall the run; fewer than two hundred cycles are expected
    initial begin
        idle(5000);
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
